// File: hw/wdg_service_logic.sv
// Purpose: watchdog timer with service location, config mirror and monitor hold
// Assumes: mclk stands in for the oscillator output clock; rst and por synchronous
// Notes: timeout only pulses wdgReset; no interrupt path exists
//
// Operation
// - any write to the service location clears the counter, new timeout starts
// - reading the service location returns the reset vector low byte
// - watchdog never raises an interrupt; timeout only resets the device
// - monitor entered with test voltage keeps watchdog off while voltage stays
// - monitor entered by blank vectors keeps watchdog off until power-on reset
// - internal disable signal follows the configuration disable bit
// - internal rate-select signal follows the configuration rate-select bit
// - wait mode keeps counting; enabled timeout still resets the device
// - stop mode removes the counting clock and clears the prescale counter
`timescale 1ns/1ns
module wdg_service_logic
  import wdg_pkg::*;
#(
  parameter int SIM_W = SIM_W_DEF,
  parameter int CNT_W = CNT_W_DEF,
  parameter int TOUT_LONG = TOUT_LONG_DEF,
  parameter int TOUT_SHORT = TOUT_SHORT_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic por,
  input wire wdg_wb_req_s wbReq,
  output wdg_wb_rsp_s wbRsp,
  input wire wdg_mon_s mon,
  input wire logic waitMode,
  input wire logic stopMode,
  input wire logic [SVC_W-1:0] vecLowByte,
  output logic wdgReset,
  output logic wdgDisable,
  output logic wdgRateSelect,
  output logic wdgActive
);

  function automatic logic idxHit(input logic [WB_ADR_W-1:0] adr,
                                  input logic [IDX_W-1:0] idx);
    idxHit = (adr[ADR_LSB +: IDX_W] == idx);
  endfunction

  localparam logic [CNT_W-1:0] LIMIT_LONG = CNT_W'(TOUT_LONG);
  localparam logic [CNT_W-1:0] LIMIT_SHORT = CNT_W'(TOUT_SHORT);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [SIM_W-1:0] SIM_ZERO = '0;
  localparam logic [SIM_W-1:0] SIM_ONE = SIM_W'(1);

  // bus state
  logic ack_r;
  logic [WB_DAT_W-1:0] rdData_r;
  logic [WB_DAT_W-1:0] rdData_nxt;

  // configuration and status
  logic cfgDis_r;
  logic cfgRs_r;
  logic toutSeen_r;
  logic toutSeen_nxt;

  // counting
  logic [SIM_W-1:0] simCnt_r;
  logic [SIM_W-1:0] simCnt_nxt;
  logic [CNT_W-1:0] wdgCnt_r;
  logic [CNT_W-1:0] wdgCnt_nxt;
  logic wdgReset_r;
  logic active_r;

  // monitor hold
  wdg_mon_e monState_r;
  wdg_mon_e monState_nxt;
  logic monPrev_r;

  // bus decode
  wire busReq = wbReq.cyc & wbReq.stb & ~ack_r;
  wire busWr = busReq & wbReq.we;
  wire busRd = busReq & ~wbReq.we;
  wire hitSvc = idxHit(wbReq.adr, IDX_SERVICE);
  wire hitCfg = idxHit(wbReq.adr, IDX_CONFIG);
  wire hitSt = idxHit(wbReq.adr, IDX_STATUS);
  wire hitCnt = idxHit(wbReq.adr, IDX_COUNT);
  wire lane0 = wbReq.sel[0];

  // any data value, any lane, counts as service
  wire serviceWr = busWr & hitSvc;
  wire cfgWr = busWr & hitCfg & lane0;
  wire stClrWr = busWr & hitSt & lane0 & wbReq.dat[ST_TOUT_BIT];

  // monitor entry is the rising edge of the monitor level
  wire monEnter = mon.monitorMode & ~monPrev_r;
  wire tstPresent = mon.testVoltIrq | mon.testVoltRst;
  wire monHold = (monState_r != MON_NONE);

  // disable sources gate the timeout, the clock keeps the count moving
  wire wdgEnabled = ~cfgDis_r & ~monHold;

  // stop removes the count clock; wait does not appear here on purpose
  wire clkRun = ~stopMode;
  wire simWrap = clkRun & (simCnt_r == {SIM_W{1'b1}});
  wire [CNT_W-1:0] limit = cfgRs_r ? LIMIT_SHORT : LIMIT_LONG;
  wire atLimit = (wdgCnt_r >= limit);
  wire timeout = wdgEnabled & simWrap & atLimit;

  // read data, chosen on the request cycle and held with ack
  wire [WB_DAT_W-1:0] svcRead = {{(WB_DAT_W-SVC_W){1'b0}}, vecLowByte};
  wire [WB_DAT_W-1:0] cfgRead = {30'h0, cfgRs_r, cfgDis_r};
  wire [ST_W-1:0] stBits = {stopMode, waitMode, toutSeen_r,
                            monState_r == MON_BLANK, monState_r == MON_TST,
                            wdgEnabled};
  wire [WB_DAT_W-1:0] stRead = {{(WB_DAT_W-ST_W){1'b0}}, stBits};
  wire [WB_DAT_W-1:0] cntRead = WB_DAT_W'(wdgCnt_r);

  always_comb begin
    rdData_nxt = DAT_ZERO;
    if (busRd) begin
      if (hitSvc) begin
        rdData_nxt = svcRead;
      end else if (hitCfg) begin
        rdData_nxt = cfgRead;
      end else if (hitSt) begin
        rdData_nxt = stRead;
      end else if (hitCnt) begin
        rdData_nxt = cntRead;
      end
    end
  end

  // prescale counter stands for the system integration counter
  always_comb begin
    simCnt_nxt = simCnt_r + SIM_ONE;
    if (stopMode) begin
      simCnt_nxt = SIM_ZERO;
    end
  end

  // service and timeout both restart; count freezes while stopped
  always_comb begin
    wdgCnt_nxt = wdgCnt_r;
    if (serviceWr | timeout) begin
      wdgCnt_nxt = CNT_ZERO;
    end else if (simWrap & ~atLimit) begin
      wdgCnt_nxt = wdgCnt_r + CNT_ONE;
    end
  end

  // sticky timeout flag: a new timeout beats a clear in the same cycle
  always_comb begin
    toutSeen_nxt = toutSeen_r;
    if (stClrWr) begin
      toutSeen_nxt = 1'b0;
    end
    if (wdgReset_r) begin
      toutSeen_nxt = 1'b1;
    end
  end

  // monitor hold: tst hold ends with the voltage, blank hold only by power-on
  always_comb begin
    monState_nxt = monState_r;
    unique case (monState_r)
      MON_NONE: begin
        if (monEnter & mon.testVoltIrq) begin
          monState_nxt = MON_TST;
        end else if (monEnter & mon.blankVectors) begin
          monState_nxt = MON_BLANK;
        end
      end
      MON_TST: begin
        if (~tstPresent) begin
          monState_nxt = MON_NONE;
        end
      end
      MON_BLANK: begin
        monState_nxt = MON_BLANK;
      end
      // the fourth code of the two-bit state is unused; fall back to no hold
      default: begin
        monState_nxt = MON_NONE;
      end
    endcase
  end

  // bus slave: one-cycle answer, ack drops the cycle after
  always_ff @(posedge mclk) begin
    if (rst | por) begin
      ack_r <= 1'b0;
      rdData_r <= DAT_ZERO;
    end else begin
      ack_r <= busReq;
      rdData_r <= rdData_nxt;
    end
  end

  // config bits are software writable and mirrored out
  always_ff @(posedge mclk) begin
    if (rst | por) begin
      cfgDis_r <= CFG_DIS_RST;
      cfgRs_r <= CFG_RS_RST;
    end else if (cfgWr) begin
      cfgDis_r <= wbReq.dat[CFG_DIS_BIT];
      cfgRs_r <= wbReq.dat[CFG_RS_BIT];
    end
  end

  // counters restart from zero after any reset
  always_ff @(posedge mclk) begin
    if (rst | por) begin
      simCnt_r <= SIM_ZERO;
      wdgCnt_r <= CNT_ZERO;
    end else begin
      simCnt_r <= simCnt_nxt;
      wdgCnt_r <= wdgCnt_nxt;
    end
  end

  // timeout is a reset request pulse, never an interrupt
  always_ff @(posedge mclk) begin
    if (rst | por) begin
      wdgReset_r <= 1'b0;
    end else begin
      wdgReset_r <= timeout;
    end
  end

  // timeout flag survives system reset so software can see the cause
  always_ff @(posedge mclk) begin
    if (por) begin
      toutSeen_r <= 1'b0;
    end else begin
      toutSeen_r <= toutSeen_nxt;
    end
  end

  // monitor hold is cleared by power-on only, not by system reset
  always_ff @(posedge mclk) begin
    if (por) begin
      monState_r <= MON_NONE;
      monPrev_r <= 1'b0;
    end else begin
      monState_r <= monState_nxt;
      monPrev_r <= mon.monitorMode;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst | por) begin
      active_r <= 1'b0;
    end else begin
      active_r <= wdgEnabled;
    end
  end

  assign wbRsp.ack = ack_r;
  assign wbRsp.dat = rdData_r;
  assign wdgReset = wdgReset_r;
  assign wdgDisable = cfgDis_r;
  assign wdgRateSelect = cfgRs_r;
  assign wdgActive = active_r;

endmodule

// File: hw/wdg_pkg.sv
// Purpose: shared constants and carriers for the watchdog service logic
// Assumes: classic wishbone, 32-bit data, byte addresses, word-aligned registers
// Notes: register byte address is four times its index
package wdg_pkg;

  localparam int WB_ADR_W = 20;
  localparam int WB_DAT_W = 32;
  localparam int WB_SEL_W = 4;
  localparam int IDX_W = 18;
  localparam int ADR_LSB = 2;

  // register indices; byte address = index * 4
  localparam logic [IDX_W-1:0] IDX_SERVICE = 18'h0ffff;
  localparam logic [IDX_W-1:0] IDX_CONFIG = 18'h0fff0;
  localparam logic [IDX_W-1:0] IDX_STATUS = 18'h0fff1;
  localparam logic [IDX_W-1:0] IDX_COUNT = 18'h0fff2;

  // configuration register fields
  localparam int CFG_DIS_BIT = 0;
  localparam int CFG_RS_BIT = 1;
  localparam logic CFG_DIS_RST = 1'h0;
  localparam logic CFG_RS_RST = 1'h0;

  // status register fields
  localparam int ST_EN_BIT = 0;
  localparam int ST_TST_BIT = 1;
  localparam int ST_BLANK_BIT = 2;
  localparam int ST_TOUT_BIT = 3;
  localparam int ST_WAIT_BIT = 4;
  localparam int ST_STOP_BIT = 5;
  localparam int ST_W = 6;

  // service register holds one byte
  localparam int SVC_W = 8;

  // default timeout counts, in prescaled ticks
  localparam int SIM_W_DEF = 4;
  localparam int CNT_W_DEF = 18;
  localparam int TOUT_LONG_DEF = 262143;
  localparam int TOUT_SHORT_DEF = 8191;

  localparam logic [WB_DAT_W-1:0] DAT_ZERO = 32'h0;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [WB_ADR_W-1:0] adr;
    logic [WB_SEL_W-1:0] sel;
    logic [WB_DAT_W-1:0] dat;
  } wdg_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [WB_DAT_W-1:0] dat;
  } wdg_wb_rsp_s;

  typedef struct packed {
    logic monitorMode;
    logic testVoltIrq;
    logic testVoltRst;
    logic blankVectors;
  } wdg_mon_s;

  typedef enum logic [1:0] {
    MON_NONE,
    MON_TST,
    MON_BLANK
  } wdg_mon_e;

endpackage

// File: test/wdg_service_logic_assertions.sv
// Purpose: port checks for the watchdog service logic
// Assumes: one clock; rst or por disables every check
// Notes: hold checks allow a few cycles of entry latency
`timescale 1ns/1ns
module wdg_service_logic_assertions
  import wdg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic por,
  input wire wdg_wb_req_s wbReq,
  input wire wdg_wb_rsp_s wbRsp,
  input wire wdg_mon_s mon,
  input wire logic [SVC_W-1:0] vecLowByte,
  input wire logic wdgReset,
  input wire logic wdgDisable,
  input wire logic wdgActive
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst || por);
  wire take = wbReq.cyc && wbReq.stb && !wbRsp.ack;
  wire svcHit = take && (wbReq.adr[19:2] == IDX_SERVICE);
  sequence sSvcWr; svcHit && wbReq.we; endsequence
  sequence sSvcRd; svcHit && !wbReq.we; endsequence
  // entry latency plus the delayed active flag fits in four cycles
  sequence sTstHeld;
    $rose(mon.monitorMode) && mon.testVoltIrq ##1 (mon.testVoltIrq || mon.testVoltRst) [*4];
  endsequence
  sequence sBlankIn;
    $rose(mon.monitorMode) && !mon.testVoltIrq && mon.blankVectors ##4 1'h1;
  endsequence
  chk_ack_next: assert property (take |=> wbRsp.ack)
    else $error("no ack");
  chk_ack_pulse: assert property (wbRsp.ack |=> !wbRsp.ack)
    else $error("ack stuck");
  chk_svc_read: assert property (sSvcRd |=> wbRsp.dat == {24'h0, $past(vecLowByte)})
    else $error("bad service data");
  chk_svc_restart: assert property (sSvcWr |=> ##1 !wdgReset [*6])
    else $error("reset after service");
  chk_pulse_once: assert property (wdgReset |=> !wdgReset [*3])
    else $error("long reset");
  chk_dis_block: assert property (wdgDisable [*4] |-> !wdgReset)
    else $error("reset while disabled");
  chk_tst_hold: assert property (sTstHeld |-> !wdgActive && !wdgReset)
    else $error("active in test hold");
  chk_blank_hold: assert property (sBlankIn |-> !wdgActive)
    else $error("active in blank hold");
endmodule
bind wdg_service_logic wdg_service_logic_assertions i_chk (.mclk(mclk), .rst(rst),
  .por(por), .wbReq(wbReq), .wbRsp(wbRsp), .mon(mon), .vecLowByte(vecLowByte),
  .wdgReset(wdgReset), .wdgDisable(wdgDisable), .wdgActive(wdgActive));

// File: test/test_wdg_service_logic.sv
// Purpose: register-level test of the watchdog service logic
// Assumes: limits cut to 20 and 5 ticks of 4 cycles
// Notes: windows leave margin for prescaler phase
`timescale 1ns/1ns
module test_wdg_service_logic
  import wdg_pkg::*;
;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic por = 1'h1;
  logic waitMode = 1'h0;
  logic stopMode = 1'h0;
  logic [SVC_W-1:0] vecLowByte = 8'h5a;
  wdg_wb_req_s wbReq = '0;
  wdg_mon_s mon = '0;
  wdg_wb_rsp_s wbRsp;
  logic wdgReset, wdgDisable, wdgRateSelect, wdgActive;
  logic [WB_DAT_W-1:0] rd;
  int mismatches = 0;
  int checks = 0;
  int pulses = 0;
  wdg_service_logic #(.SIM_W(2), .TOUT_LONG(20), .TOUT_SHORT(5)) i_wdg_service_logic (
    .mclk(mclk), .rst(rst), .por(por), .wbReq(wbReq), .wbRsp(wbRsp), .mon(mon),
    .waitMode(waitMode), .stopMode(stopMode), .vecLowByte(vecLowByte),
    .wdgReset(wdgReset), .wdgDisable(wdgDisable), .wdgRateSelect(wdgRateSelect),
    .wdgActive(wdgActive));
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) if (wdgReset === 1'h1) pulses <= pulses + 1;
  task automatic chk(input logic [WB_DAT_W-1:0] seen, input logic [WB_DAT_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one request at a time; released at the edge that samples ack, or after 16 more edges with no ack
  task automatic acc(input logic we, input logic [IDX_W-1:0] idx, input logic [WB_DAT_W-1:0] d);
    int n;
    n = 0;
    wbReq <= '{1'h1, 1'h1, we, {idx, 2'h0}, 4'hf, d};
    @(posedge mclk);
    while (wbRsp.ack !== 1'h1 && n < 16) begin
      @(posedge mclk);
      n++;
    end
    chk(wbRsp.ack, 1'h1);
    rd = wbRsp.dat;
    wbReq <= '0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [WB_DAT_W-1:0] d);
    acc(1'h1, idx, d);
  endtask
  task automatic rdc(input logic [IDX_W-1:0] idx, input logic [WB_DAT_W-1:0] e);
    acc(1'h0, idx, DAT_ZERO);
    chk(rd, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #40000;
    mismatches++;
    conclude;
  end
  initial begin
    wt(20);
    rst <= 1'h0;
    por <= 1'h0;
    @(posedge mclk);
    rdc(IDX_CONFIG, DAT_ZERO);
    rdc(IDX_SERVICE, {24'h0, vecLowByte});
    rdc(18'h00001, DAT_ZERO);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CONFIG, i);
      rdc(IDX_CONFIG, i);
      chk({wdgRateSelect, wdgDisable}, i);
    end
    $display("test registers done");
    wr(IDX_CONFIG, 32'h2);
    wr(IDX_SERVICE, 32'hff);
    pulses = 0;
    wt(14);
    chk(pulses, 0);
    wt(20);
    chk(pulses, 1);
    pulses = 0;
    for (int i = 0; i < 8; i++) begin
      wr(IDX_SERVICE, i * 33);
      wt(10);
    end
    chk(pulses, 0);
    $display("test short timeout done");
    waitMode <= 1'h1;
    wr(IDX_CONFIG, DAT_ZERO);
    wr(IDX_SERVICE, DAT_ZERO);
    pulses = 0;
    wt(70);
    chk(pulses, 0);
    wt(24);
    chk(pulses, 1);
    waitMode <= 1'h0;
    $display("test wait done");
    wr(IDX_SERVICE, DAT_ZERO);
    stopMode <= 1'h1;
    pulses = 0;
    wt(200);
    chk(pulses, 0);
    stopMode <= 1'h0;
    wr(IDX_SERVICE, DAT_ZERO);
    $display("test stop done");
    wr(IDX_CONFIG, 32'h2);
    mon <= '{1'h1, 1'h1, 1'h1, 1'h0};
    pulses = 0;
    wt(60);
    mon <= '{1'h1, 1'h0, 1'h1, 1'h0};
    wt(40);
    chk(pulses, 0);
    chk(wdgActive, 1'h0);
    mon <= '{1'h1, 1'h0, 1'h0, 1'h0};
    wt(12);
    chk(pulses, 1);
    chk(wdgActive, 1'h1);
    mon <= '0;
    $display("test voltage hold done");
    wt(2);
    mon <= '{1'h1, 1'h0, 1'h0, 1'h1};
    wt(4);
    mon <= '0;
    pulses = 0;
    wt(40);
    rst <= 1'h1;
    wt(2);
    rst <= 1'h0;
    @(posedge mclk);
    wr(IDX_CONFIG, 32'h2);
    wt(60);
    chk(pulses, 0);
    chk(wdgActive, 1'h0);
    por <= 1'h1;
    wt(2);
    por <= 1'h0;
    @(posedge mclk);
    wr(IDX_CONFIG, 32'h2);
    wr(IDX_SERVICE, DAT_ZERO);
    pulses = 0;
    wt(34);
    chk(pulses, 1);
    chk(wdgActive, 1'h1);
    rdc(IDX_STATUS, 32'h9);
    wr(IDX_STATUS, 32'h8);
    rdc(IDX_STATUS, 32'h1);
    $display("test blank hold done");
    conclude;
  end
endmodule
